// ===== src/sync_serial_control_clocking.sv
// control, write lock and clock setup of the synchronous serial controller
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`include "ssc_ctrl_regs.svh"
//
// Overview of operation
// [RULE_01] receive on command enables receiver unless receive off set same write
// [RULE_02] receive off stops receiver after current character finishes
// [RULE_03] transmit on command enables transmitter unless transmit off set same write
// [RULE_04] transmit off stops transmitter after current character shifts out
// [RULE_05] soft reset resets controller, overriding all other control bits
// [RULE_06] divider field zero: no divided bit clock
// [RULE_07] nonzero divider: divided clock equals master clock over twice field
// [RULE_08] divider field is 12 bits, up to 4095
// [RULE_09] clock setup writes ignored while write lock enabled
// [RULE_10] receive clock source: 0 divided, 1 transmit clock, 2 pin, 3 reserved
// [RULE_11] locked write sets violation flag and records target register
// [RULE_12] invert clear samples on falling receive edge, set on rising
// [RULE_13] clock output mode: 0 input, 1 continuous, 2 only during transfer
// [RULE_14] soft reset stops both directions and restores register reset values; lock setup and lock violation keep their values
module sync_serial_control_clocking #(
   parameter int CHAR_BITS = `CHAR_BITS_DEFAULT
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clkEn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link clocks
   input wire logic txClockSignal,
   input wire logic rxClockPinIn,
   output logic rxClockPinOut,
   output logic rxClockPinOe,
   // to frame logic
   output logic divClock,
   output logic rxSampleStrobe,
   output logic rxEnabled,
   output logic txEnabled,
   output logic irq
);
   logic [31:0] cmrReg, rcmrReg, rfmrReg, tcmrReg, tfmrReg, tshrReg, rc0Reg, rc1Reg;
   logic [31:0] imrReg, statusReg;
   logic lockReg, violReg;
   logic [7:0] violSrcReg;
   logic [`DIV_WIDTH-1:0] divCnt_reg;
   logic divClk_reg;
   ssc_ctrl_pkg::dir_state_e rxState_reg, txState_reg;
   logic [5:0] rxBit_reg, txBit_reg;
   logic rxClkSel_reg, rxClkPrev_reg;

   ssc_ctrl_pkg::apb_req_s req;
   assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

   // decode
   wire access = req.sel && req.enable && clkEn;
   wire wrAcc = access && req.write;
   wire wrCtrl = wrAcc && req.addr == `OFF_CONTROL_COMMANDS;
   wire softReset = wrCtrl && req.wdata[`BIT_SOFT_RESET]; // [RULE_05]
   wire cmdRxOn = wrCtrl && !softReset && req.wdata[`BIT_RX_ON] && !req.wdata[`BIT_RX_OFF];
   wire cmdRxOff = wrCtrl && !softReset && req.wdata[`BIT_RX_OFF];
   wire cmdTxOn = wrCtrl && !softReset && req.wdata[`BIT_TX_ON] && !req.wdata[`BIT_TX_OFF];
   wire cmdTxOff = wrCtrl && !softReset && req.wdata[`BIT_TX_OFF];
   wire isProtected = req.addr == `OFF_CLOCK_DIVIDER_SETUP || req.addr == `OFF_RX_CLOCK_SETUP
      || req.addr == `OFF_RX_FRAME_SETUP || req.addr == `OFF_TX_CLOCK_SETUP
      || req.addr == `OFF_TX_FRAME_SETUP || req.addr == `OFF_RX_MATCH_A
      || req.addr == `OFF_RX_MATCH_B;
   wire wrBlocked = wrAcc && isProtected && lockReg; // [RULE_09]
   wire wrOk = wrAcc && !(isProtected && lockReg);
   wire wrLock = wrOk && req.addr == `OFF_LOCK_SETUP;
   wire [`DIV_WIDTH-1:0] divField = cmrReg[`DIV_WIDTH-1:0]; // [RULE_08]
   wire [1:0] clkSource = rcmrReg[`POS_CLK_SOURCE +: 2];
   wire [2:0] clkOutMode = rcmrReg[`POS_CLK_OUT_MODE +: 3];
   wire clkInvert = rcmrReg[`POS_CLK_INVERT];

   // receive clock source selection
   logic rxClkRaw;
   always_comb begin
      case (clkSource) // [RULE_10]
         2'h0: rxClkRaw = divClk_reg;
         2'h1: rxClkRaw = txClockSignal;
         2'h2: rxClkRaw = rxClockPinIn;
         default: rxClkRaw = 1'b0;
      endcase
   end
   // sampling edge chosen by inversion
   wire rxEdge = clkInvert ? (rxClkSel_reg && !rxClkPrev_reg)
      : (!rxClkSel_reg && rxClkPrev_reg); // [RULE_12]
   wire txEdge = divClk_reg && (divCnt_reg == `DIV_WIDTH'(1)) && divField != '0;
   wire rxLast = rxEdge && rxBit_reg == 6'(CHAR_BITS - 1);
   wire txLast = txEdge && txBit_reg == 6'(CHAR_BITS - 1);

   wire [31:0] statusLive = `STATUS_RESET | (32'(txState_reg != ssc_ctrl_pkg::DIR_OFF) << `ST_TX_ON)
      | (32'(rxState_reg != ssc_ctrl_pkg::DIR_OFF) << `ST_RX_ON) | (32'(violReg) << `ST_VIOLATION);

   // readback mux
   logic [31:0] rdMux;
   always_comb begin
      case (req.addr)
         `OFF_CLOCK_DIVIDER_SETUP: rdMux = cmrReg;
         `OFF_RX_CLOCK_SETUP: rdMux = rcmrReg;
         `OFF_RX_FRAME_SETUP: rdMux = rfmrReg;
         `OFF_TX_CLOCK_SETUP: rdMux = tcmrReg;
         `OFF_TX_FRAME_SETUP: rdMux = tfmrReg;
         `OFF_TX_SYNC_WORD: rdMux = tshrReg;
         `OFF_RX_MATCH_A: rdMux = rc0Reg;
         `OFF_RX_MATCH_B: rdMux = rc1Reg;
         `OFF_CONTROLLER_STATUS: rdMux = statusReg;
         `OFF_IRQ_ENABLE_VIEW: rdMux = imrReg;
         `OFF_LOCK_SETUP: rdMux = {31'h0, lockReg};
         `OFF_LOCK_VIOLATION: rdMux = {16'h0, violSrcReg, 7'h0, violReg};
         default: rdMux = 32'h0;
      endcase
   end
   wire mapped = req.addr[1:0] == 2'h0 && (req.addr <= `OFF_EVENT_CLEAR
      || req.addr == `OFF_LOCK_SETUP || req.addr == `OFF_LOCK_VIOLATION);

   // apb answer: ready one cycle after setup, registered
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else if (clkEn) begin
         pready <= req.sel && !req.enable;
         prdata <= (req.sel && !req.enable && !req.write) ? rdMux : 32'h0;
         pslverr <= req.sel && !req.enable && !mapped;
      end
   end

   // configuration registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cmrReg <= 32'h0;
         rcmrReg <= 32'h0;
         rfmrReg <= 32'h0;
         tcmrReg <= 32'h0;
         tfmrReg <= 32'h0;
         tshrReg <= 32'h0;
         rc0Reg <= 32'h0;
         rc1Reg <= 32'h0;
         imrReg <= 32'h0;
      end else if (softReset) begin // [RULE_14]
         cmrReg <= 32'h0;
         rcmrReg <= 32'h0;
         rfmrReg <= 32'h0;
         tcmrReg <= 32'h0;
         tfmrReg <= 32'h0;
         tshrReg <= 32'h0;
         rc0Reg <= 32'h0;
         rc1Reg <= 32'h0;
         imrReg <= 32'h0;
      end else if (wrOk) begin
         case (req.addr)
            `OFF_CLOCK_DIVIDER_SETUP: cmrReg <= {20'h0, req.wdata[`DIV_WIDTH-1:0]};
            `OFF_RX_CLOCK_SETUP: rcmrReg <= req.wdata;
            `OFF_RX_FRAME_SETUP: rfmrReg <= req.wdata;
            `OFF_TX_CLOCK_SETUP: tcmrReg <= req.wdata;
            `OFF_TX_FRAME_SETUP: tfmrReg <= req.wdata;
            `OFF_TX_SYNC_WORD: tshrReg <= req.wdata;
            `OFF_RX_MATCH_A: rc0Reg <= req.wdata;
            `OFF_RX_MATCH_B: rc1Reg <= req.wdata;
            `OFF_IRQ_ENABLE_SET: imrReg <= imrReg | req.wdata;
            `OFF_IRQ_ENABLE_CLEAR: imrReg <= imrReg & ~req.wdata;
            default: imrReg <= imrReg;
         endcase
      end
   end

   // write lock and violation record
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lockReg <= 1'b0;
         violReg <= 1'b0;
         violSrcReg <= 8'h0;
      end else if (clkEn) begin
         if (wrLock) lockReg <= req.wdata[`BIT_LOCK_ENABLE];
         if (wrBlocked) begin // [RULE_11]
            violReg <= 1'b1;
            violSrcReg <= req.addr;
         end else if (wrLock) begin
            violReg <= 1'b0;
         end
      end
   end

   // sticky status: events set, clear register clears, set wins
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         statusReg <= `STATUS_RESET;
      end else if (clkEn) begin
         if (softReset) statusReg <= `STATUS_RESET; // [RULE_14]
         else if (wrOk && req.addr == `OFF_EVENT_CLEAR)
            statusReg <= (statusReg & ~req.wdata) | statusLive;
         else statusReg <= statusReg | statusLive;
      end
   end

   // divided clock: toggles every divField master cycles
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         divCnt_reg <= '0;
         divClk_reg <= 1'b0;
      end else if (clkEn) begin
         if (divField == '0) begin // [RULE_06]
            divCnt_reg <= '0;
            divClk_reg <= 1'b0;
         end else if (divCnt_reg >= divField - `DIV_WIDTH'(1)) begin // [RULE_07]
            divCnt_reg <= '0;
            divClk_reg <= !divClk_reg;
         end else begin
            divCnt_reg <= divCnt_reg + `DIV_WIDTH'(1);
         end
      end
   end

   // receive clock edge tracking
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rxClkSel_reg <= 1'b0;
         rxClkPrev_reg <= 1'b0;
      end else if (clkEn) begin
         rxClkSel_reg <= rxClkRaw;
         rxClkPrev_reg <= rxClkSel_reg;
      end
   end

   // receive direction state
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rxState_reg <= ssc_ctrl_pkg::DIR_OFF;
         rxBit_reg <= '0;
      end else if (clkEn) begin
         if (softReset) begin // [RULE_14]
            rxState_reg <= ssc_ctrl_pkg::DIR_OFF;
            rxBit_reg <= '0;
         end else begin
            if (rxState_reg != ssc_ctrl_pkg::DIR_OFF && rxEdge)
               rxBit_reg <= rxLast ? 6'h0 : rxBit_reg + 6'h1;
            case (rxState_reg)
               ssc_ctrl_pkg::DIR_OFF: if (cmdRxOn) rxState_reg <= ssc_ctrl_pkg::DIR_ON; // [RULE_01]
               ssc_ctrl_pkg::DIR_ON: if (cmdRxOff) // [RULE_02]
                  rxState_reg <= rxBit_reg == 6'h0 && !rxEdge ? ssc_ctrl_pkg::DIR_OFF
                     : ssc_ctrl_pkg::DIR_DRAIN;
               ssc_ctrl_pkg::DIR_DRAIN: if (rxLast) rxState_reg <= ssc_ctrl_pkg::DIR_OFF;
               default: rxState_reg <= ssc_ctrl_pkg::DIR_OFF;
            endcase
         end
      end
   end

   // transmit direction state
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         txState_reg <= ssc_ctrl_pkg::DIR_OFF;
         txBit_reg <= '0;
      end else if (clkEn) begin
         if (softReset) begin // [RULE_14]
            txState_reg <= ssc_ctrl_pkg::DIR_OFF;
            txBit_reg <= '0;
         end else begin
            if (txState_reg != ssc_ctrl_pkg::DIR_OFF && txEdge)
               txBit_reg <= txLast ? 6'h0 : txBit_reg + 6'h1;
            case (txState_reg)
               ssc_ctrl_pkg::DIR_OFF: if (cmdTxOn) txState_reg <= ssc_ctrl_pkg::DIR_ON; // [RULE_03]
               ssc_ctrl_pkg::DIR_ON: if (cmdTxOff) // [RULE_04]
                  txState_reg <= txBit_reg == 6'h0 && !txEdge ? ssc_ctrl_pkg::DIR_OFF
                     : ssc_ctrl_pkg::DIR_DRAIN;
               ssc_ctrl_pkg::DIR_DRAIN: if (txLast) txState_reg <= ssc_ctrl_pkg::DIR_OFF;
               default: txState_reg <= ssc_ctrl_pkg::DIR_OFF;
            endcase
         end
      end
   end

   // registered outputs
   wire rxActive = rxState_reg != ssc_ctrl_pkg::DIR_OFF;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         divClock <= 1'b0;
         rxSampleStrobe <= 1'b0;
         rxEnabled <= 1'b0;
         txEnabled <= 1'b0;
         irq <= 1'b0;
         rxClockPinOut <= 1'b0;
         rxClockPinOe <= 1'b1;
      end else if (clkEn) begin
         divClock <= divClk_reg;
         rxSampleStrobe <= rxEdge && rxActive; // [RULE_12]
         rxEnabled <= rxActive;
         txEnabled <= txState_reg != ssc_ctrl_pkg::DIR_OFF;
         irq <= |(statusReg & imrReg);
         rxClockPinOut <= divClk_reg;
         case (clkOutMode) // [RULE_13]
            3'h1: rxClockPinOe <= 1'b0;
            3'h2: rxClockPinOe <= !rxActive;
            default: rxClockPinOe <= 1'b1;
         endcase
      end
   end
endmodule : sync_serial_control_clocking

// ===== src/ssc_ctrl_regs.svh
// register offsets, field positions and reset values of the serial controller
`ifndef SSC_CTRL_REGS_SVH
`define SSC_CTRL_REGS_SVH
`define OFF_CONTROL_COMMANDS 8'h00
`define OFF_CLOCK_DIVIDER_SETUP 8'h04
`define OFF_RX_CLOCK_SETUP 8'h10
`define OFF_RX_FRAME_SETUP 8'h14
`define OFF_TX_CLOCK_SETUP 8'h18
`define OFF_TX_FRAME_SETUP 8'h1C
`define OFF_RX_DATA_WORD 8'h20
`define OFF_TX_DATA_WORD 8'h24
`define OFF_RX_SYNC_WORD 8'h30
`define OFF_TX_SYNC_WORD 8'h34
`define OFF_RX_MATCH_A 8'h38
`define OFF_RX_MATCH_B 8'h3C
`define OFF_CONTROLLER_STATUS 8'h40
`define OFF_IRQ_ENABLE_SET 8'h44
`define OFF_IRQ_ENABLE_CLEAR 8'h48
`define OFF_IRQ_ENABLE_VIEW 8'h4C
`define OFF_EVENT_CLEAR 8'h50
`define OFF_LOCK_SETUP 8'hE4
`define OFF_LOCK_VIOLATION 8'hE8
`define BIT_RX_ON 0
`define BIT_RX_OFF 1
`define BIT_TX_ON 8
`define BIT_TX_OFF 9
`define BIT_SOFT_RESET 15
`define BIT_LOCK_ENABLE 0
`define BIT_VIOLATION 0
`define POS_VIOLATION_SRC 8
`define DIV_WIDTH 12
`define POS_CLK_SOURCE 0
`define POS_CLK_OUT_MODE 2
`define POS_CLK_INVERT 5
`define STATUS_RESET 32'h000000CC
`define ST_TX_ON 16
`define ST_RX_ON 17
`define ST_VIOLATION 18
`define CHAR_BITS_DEFAULT 8
`endif

// ===== src/ssc_ctrl_pkg.sv
// types shared by the serial controller
package ssc_ctrl_pkg;
   typedef enum {DIR_OFF, DIR_ON, DIR_DRAIN} dir_state_e;
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [7:0] addr;
      logic [31:0] wdata;
   } apb_req_s;
endpackage : ssc_ctrl_pkg

// ===== verification/ssc_ctrl_properties.sv
// port assertions for the serial controller control and clock setup
`timescale 1ns/1ns
module ssc_ctrl_checker #(
   parameter int CHAR_BITS = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clkEn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // clocks and states
   input wire logic rxClockPinOut,
   input wire logic rxClockPinOe,
   input wire logic divClock,
   input wire logic rxSampleStrobe,
   input wire logic rxEnabled,
   input wire logic txEnabled
);
   logic lockReg;
   logic [11:0] divReg;
   wire wr = psel && penable && pwrite && clkEn;
   wire cmdWr = wr && paddr == 8'h00;
   wire swr = cmdWr && pwdata[15];
   // shadow of lock and divider as seen from the bus
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lockReg <= 1'b0;
         divReg <= 12'h000;
      end else begin
         if (wr && paddr == 8'hE4) lockReg <= pwdata[0];
         if (swr) divReg <= 12'h000;
         else if (wr && paddr == 8'h04 && !lockReg) divReg <= pwdata[11:0];
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
   ready_access_a: assert property (pready |-> psel && penable) else $error("stray pready");
   err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
   rx_on_a: assert property (cmdWr && pwdata[0] && !pwdata[1] && !pwdata[15]
      |-> ##2 rxEnabled) else $error("receiver not on");
   tx_on_a: assert property (cmdWr && pwdata[8] && !pwdata[9] && !pwdata[15]
      |-> ##2 txEnabled) else $error("transmitter not on");
   tx_both_a: assert property (cmdWr && pwdata[9:8] == 2'h3 && !txEnabled
      |-> ##2 !txEnabled) else $error("transmitter on despite off bit");
   soft_reset_a: assert property (swr |-> ##2 !rxEnabled && !txEnabled)
      else $error("soft reset left a direction on");
   div_idle_a: assert property ((divReg == 12'h000) [*3] |-> !divClock)
      else $error("divided clock runs with zero divider");
   div_fast_a: assert property ((divReg == 12'h001) [*8] |-> divClock != $past(divClock))
      else $error("divider one not toggling each cycle");
   pin_drive_a: assert property (!rxClockPinOe |-> rxClockPinOut == divClock)
      else $error("driven pin not the divided clock");
   strobe_on_a: assert property (rxSampleStrobe |-> rxEnabled)
      else $error("sampling while receiver off");
   cover property (rxEnabled && rxSampleStrobe);
   cover property (swr);
   cover property (!rxClockPinOe);
endmodule : ssc_ctrl_checker
bind sync_serial_control_clocking ssc_ctrl_checker #(.CHAR_BITS(CHAR_BITS)) i_ssc_ctrl_checker (
   .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .rxClockPinOut(rxClockPinOut), .rxClockPinOe(rxClockPinOe), .divClock(divClock),
   .rxSampleStrobe(rxSampleStrobe), .rxEnabled(rxEnabled), .txEnabled(txEnabled));

// ===== verification/codec_peer_model.sv
// far-side serial peer, clocks stand low outside frames
`timescale 1ns/1ns
module codec_peer_model #(
   parameter int HALF = 2
) (
   // control
   input wire logic sysClk,
   input wire logic run,
   // link clocks
   output logic txClk,
   output logic rxPin
);
   int cnt;
   initial begin
      cnt = 0;
      txClk = 1'b0;
      rxPin = 1'b0;
   end
   always @(posedge sysClk) begin
      if (!run) begin
         cnt <= 0;
         txClk <= 1'b0;
         rxPin <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         txClk <= !txClk;
         rxPin <= !rxPin;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : codec_peer_model

// ===== verification/test_sync_serial_control_clocking.sv
// self-checking bench of the serial controller control and clock setup
`timescale 1ns/1ns
module test_sync_serial_control_clocking;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic peerRun = 1'b0;
   logic [31:0] prdata, q;
   logic pready, pslverr, txClk, peerPin, pinOut, pinOe, divClock, strobe, rxOn, txOn, irq, e;
   wire rxPin = pinOe ? peerPin : pinOut;
   int err_count = 0;
   int check_count = 0;
   int n, hi, st, bad;
   localparam int CHAR_WAIT = 40;
   always #10 sys_clk = !sys_clk;
   sync_serial_control_clocking i_sync_serial_control_clocking (.sys_clk(sys_clk), .rst(rst),
      .clkEn(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .txClockSignal(txClk), .rxClockPinIn(rxPin), .rxClockPinOut(pinOut),
      .rxClockPinOe(pinOe), .divClock(divClock), .rxSampleStrobe(strobe),
      .rxEnabled(rxOn), .txEnabled(txOn), .irq(irq));
   codec_peer_model i_codec_peer_model (.sysClk(sys_clk), .run(peerRun), .txClk(txClk),
      .rxPin(peerPin));
   task automatic results();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      q = prdata;
      e = pslverr;
      if (k >= 20) err_count++;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000);
      chk(q, exp);
   endtask : rd
   task automatic watch(input logic inv);
      hi = 0;
      st = 0;
      bad = 0;
      repeat (4) @(negedge sys_clk);
      repeat (60) begin
         @(negedge sys_clk);
         if (divClock !== 1'b0) hi++;
         if (strobe === 1'b1) st++;
         if (strobe === 1'b1 && divClock !== inv) bad++;
      end
   endtask : watch
   task automatic halfper();
      n = 0;
      while (divClock !== 1'b0 && n < 9000) @(negedge sys_clk);
      while (divClock !== 1'b1 && n < 9000) @(negedge sys_clk);
      while (divClock === 1'b1 && n < 9000) begin
         @(negedge sys_clk);
         n++;
      end
   endtask : halfper
   task automatic t_regs();
      logic [7:0] ra[14] = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h30, 8'h34,
         8'h38, 8'h3C, 8'h40, 8'h4C, 8'hE4, 8'hE8};
      foreach (ra[i]) rd(ra[i], ra[i] == 8'h40 ? 32'h000000CC : 32'h00000000);
      bus(1'b0, 8'h60, 32'h00000000);
      chk({31'h0, e}, 32'h00000001);
   endtask : t_regs
   task automatic t_enable();
      wr(8'h00, 32'h00000303);
      chk({30'h0, rxOn, txOn}, 32'h00000000);
      wr(8'h00, 32'h00000101);
      chk({30'h0, rxOn, txOn}, 32'h00000003);
      bus(1'b0, 8'h40, 32'h00000000);
      chk(q & 32'h00030000, 32'h00030000);
      wr(8'h00, 32'h00000202);
      repeat (CHAR_WAIT) @(negedge sys_clk);
      chk({30'h0, rxOn, txOn}, 32'h00000000);
   endtask : t_enable
   task automatic t_div();
      wr(8'h04, 32'hFFFFFFFF);
      rd(8'h04, 32'h00000FFF);
      halfper();
      chk(32'(n), 32'h00000FFF);
      wr(8'h04, 32'h00000000);
      watch(1'b0);
      chk(32'(hi), 32'h00000000);
      wr(8'h04, 32'h00000001);
      halfper();
      chk(32'(n), 32'h00000001);
      wr(8'h04, 32'h00000003);
      halfper();
      chk(32'(n), 32'h00000003);
   endtask : t_div
   task automatic t_lock();
      wr(8'h44, 32'h00040000);
      wr(8'hE4, 32'h00000001);
      wr(8'h04, 32'h00000005);
      rd(8'h04, 32'h00000003);
      rd(8'hE8, 32'h00000401);
      wr(8'h10, 32'h00000001);
      rd(8'h10, 32'h00000000);
      rd(8'hE8, 32'h00001001);
      chk({31'h0, irq}, 32'h00000001);
      rd(8'h4C, 32'h00040000);
      wr(8'h48, 32'h00040000);
      @(negedge sys_clk);
      chk({31'h0, irq}, 32'h00000000);
      wr(8'h44, 32'h00040000);
      @(negedge sys_clk);
      chk({31'h0, irq}, 32'h00000001);
      wr(8'h50, 32'h00040000);
      @(negedge sys_clk);
      chk({31'h0, irq}, 32'h00000001);
      wr(8'hE4, 32'h00000000);
      rd(8'hE8, 32'h00001000);
      wr(8'h50, 32'h00040000);
      @(negedge sys_clk);
      chk({31'h0, irq}, 32'h00000000);
   endtask : t_lock
   task automatic t_source();
      wr(8'h00, 32'h00000001);
      peerRun <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr(8'h10, 32'(c));
         watch(1'b0);
         chk(32'(st != 0), 32'(c != 3));
         if (c == 0) chk(32'(bad), 32'h00000000);
      end
      wr(8'h10, 32'h00000020);
      watch(1'b1);
      chk(32'(bad), 32'h00000000);
      for (int m = 0; m < 3; m++) begin
         wr(8'h10, 32'(m) << 2);
         @(negedge sys_clk);
         chk({31'h0, pinOe}, 32'(m == 0));
      end
      peerRun <= 1'b0;
   endtask : t_source
   task automatic t_soft_reset_cmd();
      wr(8'h04, 32'h00000003);
      wr(8'h00, 32'h00008101);
      chk({30'h0, rxOn, txOn}, 32'h00000000);
      rd(8'h04, 32'h00000000);
      rd(8'h10, 32'h00000000);
      rd(8'h40, 32'h000000CC);
   endtask : t_soft_reset_cmd
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs();
      t_enable();
      t_div();
      t_lock();
      t_source();
      t_soft_reset_cmd();
      results();
   end
   initial begin
      repeat (60000) @(posedge sys_clk);
      err_count++;
      results();
   end
endmodule : test_sync_serial_control_clocking
